// ==== rtl/bmd_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
module bmd_decoder
  import bmd_pkg::*;
#(
  parameter int NUM_BANKS = 8,                   // Banks in the data memory.
  parameter int GPR_TOTAL = NUM_BANKS * GPR_PER_BANK // General purpose bytes really built.
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Access request from the CPU core.
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic acc_linear_i,
  input wire logic [$clog2(NUM_BANKS)-1:0] acc_bank_i,
  input wire logic [OFS_W-1:0] acc_offset_i,
  input wire logic [$clog2(GPR_TOTAL)-1:0] acc_lin_idx_i,
  input wire logic [DATA_W-1:0] acc_wdata_i,
  // Read data returned by the core and peripheral register files.
  input wire logic [DATA_W-1:0] core_rdata_i,
  input wire logic [DATA_W-1:0] periph_rdata_i,
  // Register-file strobes toward core and peripheral registers.
  output logic core_sel_o,
  output logic periph_sel_o,
  output logic ext_write_o,
  output logic [$clog2(NUM_BANKS)+OFS_W-1:0] ext_addr_o,
  output logic [DATA_W-1:0] ext_wdata_o,
  // Read answer to the CPU core.
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  output logic unimpl_o
);

  // ********************************************************************
  // Derived sizes and elaboration checks
  // ********************************************************************
  localparam int BANK_W = $clog2(NUM_BANKS);
  localparam int LIN_W = $clog2(GPR_TOTAL);
  localparam int IDX_W = LIN_W + 2; // Headroom so a banked index past the end does not wrap while GPR_TOTAL is at least NUM_BANKS*80/4.

  // A bank count that is not a power of two would leave bank numbers with no memory.
  if (NUM_BANKS < 2 || (1 << BANK_W) != NUM_BANKS) begin : g_bad_banks
    $error("NUM_BANKS must be a power of two of at least 2");
  end
  if (GPR_TOTAL < 2 || GPR_TOTAL > NUM_BANKS * GPR_PER_BANK) begin : g_bad_gpr
    $error("GPR_TOTAL must lie between 2 and NUM_BANKS*80");
  end

  // ********************************************************************
  // Request decode
  // ********************************************************************
  bmd_region_type req_region;      // Region that this request lands in.
  logic [IDX_W-1:0] gpr_idx;       // Flat general purpose index, banked or linear.
  logic gpr_hit;                   // Index falls on a built byte.
  logic [COMMON_IDX_W-1:0] com_idx; // Common RAM index, identical in every bank.
  logic [DATA_W-1:0] gpr_peek;     // Stored byte at the requested flat index.
  logic [DATA_W-1:0] com_peek;     // Stored byte at the requested common index.

  logic [DATA_W-1:0] gpr_mem [GPR_TOTAL];    // General purpose RAM, flip-flops.
  logic [DATA_W-1:0] com_mem [COMMON_BYTES]; // Common RAM, flip-flops.

  // Linear accesses skip the bank entirely and always target general purpose RAM.
  always_comb begin
    if (acc_linear_i) begin
      req_region = BMD_GPR; // [R4]
      gpr_idx = IDX_W'(acc_lin_idx_i); // [R4]
    end else begin
      req_region = bmd_region_of(acc_offset_i); // [R1] [R5]
      // Banked slices are packed back to back, 80 bytes each.
      gpr_idx = IDX_W'(acc_bank_i) * IDX_W'(GPR_PER_BANK)
              + IDX_W'(acc_offset_i - GPR_FIRST); // [R2]
    end
  end

  // Bytes beyond what is built are holes; this is how short banks are made.
  assign gpr_hit = (req_region == BMD_GPR) && (gpr_idx < IDX_W'(GPR_TOTAL)); // [R2] [R6]
  assign com_idx = acc_offset_i[COMMON_IDX_W-1:0]; // [R3]
  assign gpr_peek = gpr_hit ? gpr_mem[gpr_idx[LIN_W-1:0]] : RDATA_RST;
  assign com_peek = com_mem[com_idx];

  // ********************************************************************
  // Storage
  // ********************************************************************
  // RAM contents are not reset, which saves a clear sequence; only holes are guaranteed zero.
  always_ff @(posedge core_clk_i) begin
    if (acc_valid_i && acc_write_i && gpr_hit) begin
      gpr_mem[gpr_idx[LIN_W-1:0]] <= acc_wdata_i; // [R2] [R6]
    end
  end

  // The bank number is not used here, so every bank sees the same 16 bytes.
  always_ff @(posedge core_clk_i) begin
    if (acc_valid_i && acc_write_i && !acc_linear_i && req_region == BMD_COMMON) begin
      com_mem[com_idx] <= acc_wdata_i; // [R3]
    end
  end

  // ********************************************************************
  // Stage 1: strobes out, RAM byte captured
  // ********************************************************************
  logic s1_read_r;                 // A read is in flight.
  bmd_region_type s1_region_r;     // Region of the read in flight.
  logic [DATA_W-1:0] s1_data_r;    // RAM byte or zero for the read in flight.

  // Core and peripheral accesses are handed to their register files one cycle later.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_sel_o <= 1'b0;
      periph_sel_o <= 1'b0;
      ext_write_o <= 1'b0;
      ext_addr_o <= '0;
      ext_wdata_o <= RDATA_RST;
    end else begin
      core_sel_o <= acc_valid_i && req_region == BMD_CORE; // [R5]
      periph_sel_o <= acc_valid_i && req_region == BMD_PERIPH; // [R1]
      ext_write_o <= acc_valid_i && acc_write_i;
      ext_addr_o <= {acc_bank_i, acc_offset_i}; // [R7]
      ext_wdata_o <= acc_wdata_i;
    end
  end

  // Unbuilt general purpose bytes are flagged; the CPU may ignore the flag.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_read_r <= 1'b0;
      s1_region_r <= BMD_NONE;
      s1_data_r <= RDATA_RST;
      unimpl_o <= 1'b0;
    end else begin
      s1_read_r <= acc_valid_i && !acc_write_i;
      s1_region_r <= (req_region == BMD_GPR && !gpr_hit) ? BMD_NONE : req_region;
      unimpl_o <= acc_valid_i && req_region == BMD_GPR && !gpr_hit; // [R6]
      if (req_region == BMD_COMMON) begin
        s1_data_r <= com_peek; // [R3]
      end else begin
        s1_data_r <= gpr_peek; // [R6]
      end
    end
  end

  // ********************************************************************
  // Stage 2: read answer
  // ********************************************************************
  // Two cycles for every region keeps the CPU side free of per-region timing.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= RDATA_RST;
    end else begin
      rd_valid_o <= s1_read_r;
      // Data moves only with an answer, so the CPU may sample it late.
      if (s1_read_r) begin
        unique case (s1_region_r)
          BMD_CORE: rd_data_o <= core_rdata_i; // [R5]
          BMD_PERIPH: rd_data_o <= periph_rdata_i; // [R1]
          BMD_GPR, BMD_COMMON: rd_data_o <= s1_data_r;
          BMD_NONE: rd_data_o <= RDATA_RST; // [R6]
        endcase
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_read_issue;
    acc_valid_i && !acc_write_i;
  endsequence

  sequence seq_answer_two;
    ##1 !rd_valid_o ##1 rd_valid_o;
  endsequence

  chk_periph_window: assert property ( // [R1]
    acc_valid_i && !acc_linear_i && acc_offset_i >= PERIPH_FIRST && acc_offset_i <= PERIPH_LAST
    |=> periph_sel_o && !core_sel_o)
    else $error("peripheral offset not sent to peripheral registers");

  chk_core_window: assert property ( // [R5]
    acc_valid_i && !acc_linear_i && acc_offset_i <= CORE_LAST
    |=> core_sel_o && !periph_sel_o)
    else $error("core offset not sent to core registers");

  chk_gpr_hole_zero: assert property ( // [R2]
    seq_read_issue and (!acc_linear_i && acc_offset_i >= GPR_FIRST && acc_offset_i <= GPR_LAST
    && !gpr_hit) |-> ##2 rd_data_o == RDATA_RST)
    else $error("read beyond built bank RAM did not return zero");

  chk_common_shared: assert property ( // [R3]
    seq_read_issue and (!acc_linear_i && acc_offset_i >= COMMON_FIRST)
    |-> ##2 rd_data_o == $past(com_peek, 2))
    else $error("common RAM read returned wrong byte");

  chk_linear_read: assert property ( // [R4]
    seq_read_issue and acc_linear_i |-> ##2 rd_data_o == $past(gpr_peek, 2))
    else $error("linear read returned wrong byte");

  chk_unimpl_flag: assert property ( // [R6]
    acc_valid_i && acc_linear_i && !gpr_hit |=> unimpl_o && !core_sel_o && !periph_sel_o)
    else $error("hole access not flagged or leaked to register files");

  chk_full_addr: assert property ( // [R7]
    acc_valid_i |=> ext_addr_o == {$past(acc_bank_i), $past(acc_offset_i)})
    else $error("full address is not bank times 128 plus offset");

  chk_read_latency: assert property ( // [R6]
    seq_read_issue |-> seq_answer_two or (##1 rd_valid_o ##1 rd_valid_o))
    else $error("read answer not two cycles after request");

  // A linear access must never reach the register files.
  chk_linear_no_strobe: assert property ( // [R4]
    acc_valid_i && acc_linear_i |=> !core_sel_o && !periph_sel_o)
    else $error("linear access leaked to register files");

  // Offsets from the RAM slice upward belong to RAM, never to the register files.
  chk_ram_no_strobe: assert property ( // [R2]
    acc_valid_i && !acc_linear_i && acc_offset_i >= GPR_FIRST |=> !core_sel_o && !periph_sel_o)
    else $error("RAM offset sent to register files");

endmodule : bmd_decoder
`default_nettype wire

// ==== pkg/bmd_pkg.sv ====
// What this block does
// [R1] Offsets 0Ch-1Fh go to peripheral registers.
// [R2] Up to 80 RAM bytes per bank.
// [R3] Offsets 70h-7Fh share one 16-byte common RAM.
// [R4] Indirect pointers reach RAM linearly, no banking.
// [R5] Offsets 00h-0Bh go to core registers.
// [R6] Unimplemented locations read zero, ignore writes.
// [R7] Full address is bank times 128 plus offset.
`default_nettype none
package bmd_pkg;

  // ********************************************************************
  // Bank layout
  // ********************************************************************
  localparam int OFS_W = 7;                    // In-bank offset width, 128 bytes a bank.
  localparam int DATA_W = 8;                   // Byte-wide data memory.
  localparam int CORE_COUNT = 12;              // Core registers at the foot of each bank.
  localparam int PERIPH_COUNT = 20;            // Peripheral register window size.
  localparam int GPR_PER_BANK = 80;            // Largest general purpose RAM slice per bank.
  localparam int COMMON_BYTES = 16;            // Common RAM size.
  localparam int COMMON_IDX_W = 4;             // Index width into common RAM.
  localparam logic [6:0] CORE_LAST = 7'h0b;    // Last core register offset.
  localparam logic [6:0] PERIPH_FIRST = 7'h0c; // First peripheral register offset.
  localparam logic [6:0] PERIPH_LAST = 7'h1f;  // Last peripheral register offset.
  localparam logic [6:0] GPR_FIRST = 7'h20;    // First general purpose RAM offset.
  localparam logic [6:0] GPR_LAST = 7'h6f;     // Last general purpose RAM offset.
  localparam logic [6:0] COMMON_FIRST = 7'h70; // First common RAM offset.
  localparam logic [7:0] RDATA_RST = 8'h00;    // Read data at reset and for holes.

  // ********************************************************************
  // Region of an access
  // ********************************************************************
  typedef enum logic [2:0] {
    BMD_CORE,
    BMD_PERIPH,
    BMD_GPR,
    BMD_COMMON,
    BMD_NONE
  } bmd_region_type;

  // Classifies an in-bank offset; every offset falls in exactly one region.
  function automatic bmd_region_type bmd_region_of(input logic [6:0] ofs);
    bmd_region_type r;
    r = BMD_COMMON;
    if (ofs <= CORE_LAST) begin
      r = BMD_CORE;
    end else if (ofs <= PERIPH_LAST) begin
      r = BMD_PERIPH;
    end else if (ofs <= GPR_LAST) begin
      r = BMD_GPR;
    end
    return r;
  endfunction : bmd_region_of

endpackage : bmd_pkg
`default_nettype wire

// ==== bench/bmd_regfile_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Core and peripheral register files
// ****************************************
module bmd_regfile_model (
  // Clock.
  input wire logic clk_i,
  // Strobes from the decoder.
  input wire logic core_sel_i,
  input wire logic periph_sel_i,
  input wire logic [9:0] ext_addr_i,
  // Read data back to the decoder.
  output logic [7:0] core_rdata_o,
  output logic [7:0] periph_rdata_o
);
  logic [7:0] junk_r = 8'h5a; // Changes every cycle so a stray sample never matches.

  // Free-running pattern shown while a file is not selected.
  always_ff @(posedge clk_i) begin
    junk_r <= junk_r + 8'h01;
  end

  // Core data ignores the bank, since every bank shows one core set.
  assign core_rdata_o = core_sel_i ? ({1'b0, ext_addr_i[6:0]} ^ 8'h3c) : junk_r;
  assign periph_rdata_o = periph_sel_i ? (ext_addr_i[7:0] ^ 8'hc3) : ~junk_r;
endmodule : bmd_regfile_model
`default_nettype wire

// ==== bench/test_banked_data_memory_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Decoder bench
// ****************************************
module test_banked_data_memory_decoder;
  import bmd_pkg::*;
  localparam int GT = 496; // Bank 6 keeps 16 bytes, bank 7 none.
  logic clk = 0, rst = 1, v = 0, w = 0, l = 0;
  logic [2:0] b = 0;
  logic [6:0] o = 0;
  logic [8:0] x = 0;
  logic [7:0] d = 0, crd, prd, rdat;
  logic cs, ps, ew, rv, un;
  logic [9:0] ea;
  logic [7:0] ewd;
  logic [7:0] mem [0:511]; // Expected general purpose bytes.
  logic [7:0] cm [0:15];   // Expected common bytes.
  logic [7:0] rq [$];      // Expected read answers.
  logic [21:0] sq [$];     // Expected strobe notes: selects, write, address, data.
  logic [31:0] seed = 32'hea9cab33;
  int mismatches = 0, cmp_count = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  bmd_decoder #(.NUM_BANKS(8), .GPR_TOTAL(GT)) DUT (.core_clk_i(clk), .rst_i(rst), .acc_valid_i(v),
    .acc_write_i(w), .acc_linear_i(l), .acc_bank_i(b), .acc_offset_i(o), .acc_lin_idx_i(x),
    .acc_wdata_i(d), .core_rdata_i(crd), .periph_rdata_i(prd), .core_sel_o(cs), .periph_sel_o(ps),
    .ext_write_o(ew), .ext_addr_o(ea), .ext_wdata_o(ewd), .rd_valid_o(rv), .rd_data_o(rdat), .unimpl_o(un));
  bmd_regfile_model FAR (.clk_i(clk), .core_sel_i(cs), .periph_sel_i(ps), .ext_addr_i(ea),
    .core_rdata_o(crd), .periph_rdata_o(prd));

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    // An unknown expectation means a byte the bench never wrote, so it counts as a mismatch.
    if (seen !== exp || $isunknown(exp)) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One access; the model is updated first so back-to-back reads see new data.
  task automatic acc(input logic wi, input logic li, input logic [2:0] bi, input logic [6:0] oi,
                     input logic [8:0] xi, input logic [7:0] di);
    int f;
    logic c, p, h;
    logic [7:0] e;
    f = li ? xi : bi * 80 + oi - 32;
    c = !li && oi <= 7'h0b;
    p = !li && oi >= 7'h0c && oi <= 7'h1f;
    h = li ? (xi >= GT) : (oi >= 7'h20 && oi <= 7'h6f && f >= GT);
    e = c ? ({1'b0, oi} ^ 8'h3c) : p ? ({bi[0], oi} ^ 8'hc3) : h ? 8'h00 : (!li && oi >= 7'h70) ? cm[oi[3:0]] : mem[f];
    if (wi && !c && !p && !h) begin
      if (!li && oi >= 7'h70) cm[oi[3:0]] = di;
      else mem[f] = di;
    end
    if (!wi) rq.push_back(e);
    if (c || p || h) sq.push_back({c, p, h, wi, bi, oi, di});
    @(posedge clk);
    v <= 1;
    w <= wi;
    l <= li;
    b <= bi;
    o <= oi;
    x <= xi;
    d <= di;
  endtask : acc

  // Watches the answers and compares each with the oldest note.
  always @(negedge clk) begin
    if (!rst && rv === 1'b1) check("rd_data", rdat, rq.size() ? rq.pop_front() : 10'h3ff);
    if (!rst && (cs === 1'b1 || ps === 1'b1 || un === 1'b1)) begin
      logic [21:0] n;
      n = sq.size() ? sq.pop_front() : 22'h3fffff;
      check("selects", {cs, ps, un, ew}, n[21:18]);
      check("ext_addr", ea, n[17:8]);
      check("ext_wdata", ewd, n[7:0]);
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    repeat (12) @(posedge clk);
    check("reset", {cs, ps, rv, un}, 0);
    rst <= 0;
    for (int i = 0; i < 8; i++) begin
      acc(0, 0, i, 7'h00, 0, 0);
      acc(0, 0, i, 7'h0b, 0, 0);
      acc(1, 0, i, 7'h0c, 0, rnd());
      acc(0, 0, i, 7'h1f, 0, 0);
      acc(1, 0, i, 7'h20, 0, rnd());
      acc(0, 0, i, 7'h20, 0, 0);
      acc(1, 0, i, 7'h6f, 0, rnd());
      acc(1, 0, i, 7'h70 + i, 0, rnd());
      if (i < 7) acc(0, 1, 7 - i, 7'h05, i * 80, 0);
    end
    for (int i = 0; i < 8; i++) begin
      acc(0, 0, i, 7'h6f, 0, 0);
      acc(0, 0, 7 - i, 7'h70 + i, 0, 0);
    end
    acc(1, 0, 5, 7'h08, 0, rnd());
    acc(1, 0, 6, 7'h2f, 0, rnd());
    acc(1, 0, 6, 7'h30, 0, rnd());
    acc(0, 0, 6, 7'h30, 0, 0);
    acc(0, 0, 6, 7'h2f, 0, 0);
    acc(1, 1, 0, 0, 495, rnd());
    acc(0, 0, 6, 7'h2f, 0, 0);
    acc(1, 1, 0, 0, 500, 8'hff);
    acc(0, 1, 0, 0, 500, 0);
    acc(0, 0, 7, 7'h40, 0, 0);
    @(posedge clk);
    v <= 0;
    repeat (4) @(posedge clk);
    check("pending", rq.size() + sq.size(), 0);
    results();
  end
endmodule : test_banked_data_memory_decoder
`default_nettype wire
